// *** piet_consts.svh ***
// offsets, field positions, reset values and timing counts for the interrupt and event block
// assumes inclusion by bare name from the package and the design modules
`ifndef PIET_CONSTS_SVH
`define PIET_CONSTS_SVH
`define PIET_NUM_SRC        6
`define PIET_NUM_CHAN       8
`define PIET_PRIO_W         4
`define PIET_TRAP_BASE      8'h10
`define PIET_VEC_STEP       3'h4
`define PIET_VEC_W          24
`define PIET_CLK_MHZ        20
`define PIET_LAT_MIN_NS     78
`define PIET_LAT_MAX_NS     187
`define PIET_REF_MHZ        64
`define PIET_LAT_MIN_CYC    ((`PIET_LAT_MIN_NS * `PIET_CLK_MHZ + 999) / 1000)
`define PIET_LAT_MAX_CYC    ((`PIET_LAT_MAX_NS * `PIET_CLK_MHZ) / 1000)
`define PIET_EDGE_RISE      2'h1
`define PIET_EDGE_FALL      2'h2
`define PIET_EDGE_BOTH      2'h3
`define PIET_FSEL_PIN       2'h0
`define PIET_FSEL_CAN       2'h1
`define PIET_FSEL_SCL       2'h2
`define PIET_IDLE_PRIO      4'h0
`define PIET_CNT_W          8
`define PIET_PTR_W          16
`endif

// *** piet_cpu_model.sv ***
// cpu stand-in: takes each interrupt after a chosen delay
// assumes irq_in holds until acknowledged
`timescale 1ns/1ps
module piet_cpu_model (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // interrupt handshake
   input  wire logic       irq_in,
   input  wire logic [3:0] delay_in,
   output logic            ack_out
);
   logic [3:0] wait_cnt;
   always @(posedge ref_clk_in) begin
      if (rst_in || !irq_in || ack_out) begin
         ack_out  <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= delay_in) begin
         ack_out <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // piet_cpu_model

// *** piet_ctrl.sv ***
// Contract
// - each source routes to vector or transfer channel
// - per source request, enable and priority
// - sixteen priority levels per source
// - only strictly higher priority preempts active service
// - each source has its own vector
// - transfer steals one cycle, no vector
// - move byte or word, bump one pointer
// - counter decrements, held in continuous mode
// - zero count raises standard interrupt instead
// - trap number enters same vectored service
// - fast inputs detect rise, fall or both
// - fast input source selectable from peripherals
// - sources 0..5 use traps 10h..15h, vectors 40h..54h
// - response latency about 2 to 3 cycles
//
// interrupt arbitration and event transfer for six capture/compare sources
// assumes the cpu pulses ack and return, and grants a transfer cycle at once
`timescale 1ns/1ps
`include "piet_consts.svh"
module piet_ctrl #(
   parameter int NUM_SRC  = `PIET_NUM_SRC,
   parameter int NUM_CHAN = `PIET_NUM_CHAN
) (
   // clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_in,
   input  wire logic                        clk_en_in,
   // hardware sources
   input  wire logic [NUM_SRC-1:0]          capture_compare_unit_req_in,
   // source configuration
   input  wire piet_pkg::piet_ctrl_t [NUM_SRC-1:0] src_cfg_in,
   input  wire logic [NUM_SRC-1:0]          sw_set_in,
   input  wire logic [NUM_SRC-1:0]          sw_clr_in,
   // fast external inputs
   input  wire logic [1:0]                  fast_pin_in,
   input  wire logic [1:0]                  can_receive_line_in,
   input  wire logic                        scl_in,
   input  wire logic [3:0]                  fast_sel_in,
   input  wire logic [3:0]                  fast_edge_in,
   output logic [1:0]                       fast_flag_out,
   input  wire logic [1:0]                  fast_clr_in,
   // channel setup
   input  wire logic [NUM_CHAN-1:0]         chan_load_in,
   input  wire piet_pkg::piet_chan_t        chan_load_val_in,
   input  wire piet_pkg::piet_chcfg_t [NUM_CHAN-1:0] chan_cfg_in,
   output piet_pkg::piet_chan_t [NUM_CHAN-1:0] chan_state_out,
   // cpu side
   input  wire logic                        trap_in,
   input  wire logic [7:0]                  trap_num_in,
   input  wire logic                        ack_in,
   input  wire logic                        reti_in,
   output logic                             irq_out,
   output logic [`PIET_VEC_W-1:0]           vector_out,
   output logic [`PIET_PRIO_W-1:0]          cur_prio_out,
   output logic [NUM_SRC-1:0]               req_flag_out,
   output piet_pkg::piet_xfer_t             xfer_out,
   output logic                             steal_out
);
   localparam int LAT = `PIET_LAT_MIN_CYC;
   typedef struct packed {
      logic [NUM_SRC-1:0]                    req;
      piet_pkg::piet_chan_t [NUM_CHAN-1:0]   ch;
      piet_pkg::piet_state_t                 fsm;
      logic [3:0]                            wait_cnt;
      logic [7:0]                            pend_trap;
      logic                                  pend_is_trap;
      logic [`PIET_PRIO_W-1:0]               pend_prio;
      logic [`PIET_PRIO_W-1:0]               cur_prio;
      logic [`PIET_PRIO_W-1:0]               saved_prio;
      logic                                  irq;
      logic [`PIET_VEC_W-1:0]                vector;
      piet_pkg::piet_xfer_t                  xfer;
      logic [1:0]                            fast;
   } piet_core_t;
   piet_core_t   st;
   piet_core_t   next_st;
   logic [1:0]   fast_hit;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_fast
         piet_fast_edge u_edge (
            .ref_clk_in          (ref_clk_in),
            .rst_in              (rst_in),
            .clk_en_in           (clk_en_in),
            .pin_in              (fast_pin_in[g]),
            .can_receive_line_in (can_receive_line_in[g]),
            .scl_in              (scl_in),
            .sel_in              (fast_sel_in[2*g+1:2*g]),
            .edge_in             (fast_edge_in[2*g+1:2*g]),
            .hit_out             (fast_hit[g])
         );
      end
   endgenerate
   logic                    win_found;
   logic [2:0]              win_idx;
   logic [`PIET_PRIO_W-1:0] win_prio;
   piet_pkg::piet_ctrl_t    wc;
   logic [2:0]              wch;
   always_comb begin
      next_st = st;
      win_found = 1'b0;
      win_idx = 3'h0;
      win_prio = 4'h0;
      wc = '0;
      wch = 3'h0;
      next_st.xfer.valid = 1'b0;
      // hardware sets win over software clears
      for (int i = 0; i < NUM_SRC; i++) begin
         if (sw_clr_in[i]) begin
            next_st.req[i] = 1'b0;
         end
         if (capture_compare_unit_req_in[i] | sw_set_in[i]) begin
            next_st.req[i] = 1'b1;
         end
      end
      for (int f = 0; f < 2; f++) begin
         if (fast_clr_in[f]) begin
            next_st.fast[f] = 1'b0;
         end
         if (fast_hit[f]) begin
            next_st.fast[f] = 1'b1;
         end
      end
      // strictly higher priority than current, lowest index wins ties
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (st.req[i] && src_cfg_in[i].en
             && src_cfg_in[i].prio > st.cur_prio
             && (!win_found || src_cfg_in[i].prio >= win_prio)) begin
            win_found = 1'b1;
            win_idx = 3'(i);
            win_prio = src_cfg_in[i].prio;
         end
      end
      wc = src_cfg_in[win_idx];
      wch = wc.chan;
      unique case (st.fsm)
         piet_pkg::PIET_IDLE: begin
            if (trap_in) begin
               next_st.pend_is_trap = 1'b1;
               next_st.pend_trap = trap_num_in;
               next_st.pend_prio = st.cur_prio;
               next_st.wait_cnt = 4'(LAT);
               next_st.fsm = piet_pkg::PIET_WAIT;
            end else if (win_found && wc.use_xfer
                         && st.ch[wch].count != '0) begin
               next_st.req[win_idx] = 1'b0;
               next_st.xfer.valid = 1'b1;
               next_st.xfer.is_word = chan_cfg_in[wch].word;
               next_st.xfer.src = st.ch[wch].src_ptr;
               next_st.xfer.dst = st.ch[wch].dst_ptr;
               if (chan_cfg_in[wch].inc_dst) begin
                  next_st.ch[wch].dst_ptr = st.ch[wch].dst_ptr
                     + (chan_cfg_in[wch].word ? 16'h0002 : 16'h0001);
               end else begin
                  next_st.ch[wch].src_ptr = st.ch[wch].src_ptr
                     + (chan_cfg_in[wch].word ? 16'h0002 : 16'h0001);
               end
               if (!chan_cfg_in[wch].continuous) begin
                  next_st.ch[wch].count = st.ch[wch].count - 8'h01;
               end
            end else if (win_found) begin
               next_st.pend_is_trap = 1'b0;
               next_st.pend_trap = `PIET_TRAP_BASE + 8'(win_idx);
               next_st.pend_prio = win_prio;
               next_st.wait_cnt = 4'(LAT);
               next_st.fsm = piet_pkg::PIET_WAIT;
            end
         end
         piet_pkg::PIET_WAIT: begin
            if (st.wait_cnt > 4'h1) begin
               next_st.wait_cnt = st.wait_cnt - 4'h1;
            end else begin
               next_st.irq = 1'b1;
               next_st.vector = {14'h0000, st.pend_trap, 2'h0};
               next_st.fsm = piet_pkg::PIET_GO;
            end
         end
         piet_pkg::PIET_GO: begin
            if (ack_in) begin
               next_st.irq = 1'b0;
               if (!st.pend_is_trap
                   && st.pend_trap >= `PIET_TRAP_BASE
                   && st.pend_trap < `PIET_TRAP_BASE + 8'(NUM_SRC)) begin
                  next_st.req[3'(st.pend_trap - `PIET_TRAP_BASE)] = 1'b0;
               end
               next_st.saved_prio = st.cur_prio;
               next_st.cur_prio = st.pend_prio;
               next_st.fsm = piet_pkg::PIET_IDLE;
            end
         end
      endcase
      if (reti_in && st.fsm == piet_pkg::PIET_IDLE) begin
         next_st.cur_prio = st.saved_prio;
         next_st.saved_prio = `PIET_IDLE_PRIO;
      end
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (chan_load_in[c]) begin
            next_st.ch[c] = chan_load_val_in;
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st <= '0;
         st.fsm <= piet_pkg::PIET_IDLE;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end
   assign irq_out        = st.irq;
   assign vector_out     = st.vector;
   assign cur_prio_out   = st.cur_prio;
   assign req_flag_out   = st.req;
   assign xfer_out       = st.xfer;
   assign steal_out      = st.xfer.valid;
   assign chan_state_out = st.ch;
   assign fast_flag_out  = st.fast;
endmodule // piet_ctrl

// *** piet_ctrl_monitor.sv ***
// assertions on the interrupt and event block ports
// assumes a bind from the test top, one clock domain
`timescale 1ns/1ps
`include "piet_consts.svh"
module piet_ctrl_monitor (
   input wire logic                   ref_clk_in,
   input wire logic                   rst_in,
   input wire logic                   ack_in,
   input wire logic                   reti_in,
   input wire logic [1:0]             fast_clr_in,
   input wire logic [1:0]             fast_flag_out,
   input wire logic                   irq_out,
   input wire logic [`PIET_VEC_W-1:0] vector_out,
   input wire logic [3:0]             cur_prio_out,
   input wire piet_pkg::piet_xfer_t   xfer_out,
   input wire logic                   steal_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_wait; irq_out && !ack_in; endsequence
   sequence s_take; irq_out && ack_in; endsequence
   property p_steal; steal_out |=> !irq_out; endproperty
   a_steal: assert property (p_steal) else $error("branch right after steal");
   property p_hold; s_wait |=> irq_out; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   property p_vec; s_wait |=> $stable(vector_out); endproperty
   a_vec: assert property (p_vec) else $error("vector moved");
   property p_form; irq_out |-> vector_out[1:0] == 2'h0 && vector_out[23:10] == 14'h0; endproperty
   a_form: assert property (p_form) else $error("vector form");
   property p_clear; s_take |=> !irq_out; endproperty
   a_clear: assert property (p_clear) else $error("irq after ack");
   property p_noirq; xfer_out.valid |-> !irq_out; endproperty
   a_noirq: assert property (p_noirq) else $error("transfer with irq");
   property p_prio; !ack_in && !reti_in |=> $stable(cur_prio_out); endproperty
   a_prio: assert property (p_prio) else $error("priority moved");
   property p_fast; fast_flag_out[0] && !fast_clr_in[0] |=> fast_flag_out[0]; endproperty
   a_fast: assert property (p_fast) else $error("fast flag lost");
endmodule // piet_ctrl_monitor

// *** piet_ctrl_test.sv ***
// self-checking bench for the interrupt and event block
// assumes the cpu model acknowledges every interrupt
`timescale 1ns/1ps
`include "piet_consts.svh"
module piet_ctrl_test;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic [5:0]                  hw_req = '0, sw_set = '0, sw_clr = '0, rflag;
   piet_pkg::piet_ctrl_t [5:0]  cfg = '0, cv = '0;
   logic [1:0]                  pin = '0, can = '0, fclr = '0, fflag;
   logic                        scl = 1'b0, trap = 1'b0, reti = 1'b0, ack, irq, steal;
   logic [3:0]                  fsel = '0, fedge = '0, cur_prio, dly = '0, p;
   logic [7:0]                  ld = '0, tnum = '0;
   piet_pkg::piet_chan_t        ldv = '0;
   piet_pkg::piet_chcfg_t [7:0] ccfg = '0;
   piet_pkg::piet_chan_t [7:0]  cst;
   piet_pkg::piet_xfer_t        xf;
   logic [23:0]                 vec;
   logic [15:0]                 s, d, e;
   int                          n_errors = 0, num_checks = 0;
   localparam int               LAT_STD  = `PIET_LAT_MIN_CYC + 2;
   localparam int               LAT_TRAP = `PIET_LAT_MIN_CYC + 1;
   logic [47:0]                 qv[$], qx[$];
   always #25 clk = ~clk;
   piet_ctrl piet_ctrl_inst (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
      .capture_compare_unit_req_in(hw_req), .src_cfg_in(cfg), .sw_set_in(sw_set),
      .sw_clr_in(sw_clr), .fast_pin_in(pin), .can_receive_line_in(can), .scl_in(scl),
      .fast_sel_in(fsel), .fast_edge_in(fedge), .fast_flag_out(fflag), .fast_clr_in(fclr),
      .chan_load_in(ld), .chan_load_val_in(ldv), .chan_cfg_in(ccfg), .chan_state_out(cst),
      .trap_in(trap), .trap_num_in(tnum), .ack_in(ack), .reti_in(reti), .irq_out(irq),
      .vector_out(vec), .cur_prio_out(cur_prio), .req_flag_out(rflag), .xfer_out(xf),
      .steal_out(steal));
   piet_cpu_model piet_cpu_model_inst (.ref_clk_in(clk), .rst_in(rst), .irq_in(irq),
      .delay_in(dly), .ack_out(ack));
   task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // wait for the interrupt, check the hold-off, wait for the acknowledge, then return
   task automatic serve(logic [3:0] pr, int lat);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 60) begin
         @(negedge clk);
         k++;
      end
      chk("latency", k, lat);
      while (!(irq === 1'b1 && ack === 1'b1) && k < 80) begin
         @(negedge clk);
         k++;
      end
      if (k >= 80) n_errors++;
      repeat (6) @(negedge clk);
      chk("irq", irq, 1'b0);
      chk("prio", cur_prio, pr);
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
   endtask
   task automatic setl(int sl, logic v);
      if (sl == 0) pin <= {2{v}};
      else if (sl == 1) can <= {2{v}};
      else scl <= v;
   endtask
   always @(posedge clk) begin
      if (irq === 1'b1 && ack === 1'b1) chk("vector", vec, qv.pop_front());
      if (xf.valid === 1'b1) chk("xfer", 48'(xf), qx.pop_front());
      if (xf.valid === 1'b1) chk("steal", steal, 1'b1);
   end
   initial begin
      #(50 * 8000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h03A8));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         p = 4'($urandom_range(15, 1));
         cv[i] = '{1'b0, 1'b1, 1'b0, 3'h0, p};
         cfg <= cv;
         hw_req[i] <= 1'b1;
         dly <= 4'($urandom_range(9));
         @(posedge clk);
         hw_req[i] <= 1'b0;
         qv.push_back(48'(`PIET_TRAP_BASE + i) * `PIET_VEC_STEP);
         serve(p, LAT_STD);
         chk("flag", rflag[i], 1'b0);
      end
      $display("standard done");
      cv = '0;
      cv[1] = '{1'b0, 1'b1, 1'b0, 3'h0, 4'h5};
      cv[2] = '{1'b0, 1'b1, 1'b0, 3'h0, 4'h9};
      cv[4] = cv[2];
      cfg <= cv;
      sw_set[5] <= 1'b1;
      @(posedge clk);
      sw_set[5] <= 1'b0;
      repeat (2) @(negedge clk);
      chk("swset", rflag[5], 1'b1);
      @(posedge clk);
      sw_clr[5] <= 1'b1;
      @(posedge clk);
      sw_clr[5] <= 1'b0;
      hw_req <= 6'h16;
      @(posedge clk);
      hw_req <= '0;
      qv.push_back(48'h48);
      qv.push_back(48'h50);
      qv.push_back(48'h44);
      serve(4'h9, LAT_STD);
      serve(4'h9, LAT_STD);
      serve(4'h5, LAT_STD);
      chk("swclr", rflag[5], 1'b0);
      $display("priority done");
      for (int t = 0; t < 4; t++) begin
         tnum <= (t == 0) ? 8'h12 : 8'($urandom);
         trap <= 1'b1;
         @(posedge clk);
         trap <= 1'b0;
         qv.push_back(48'(tnum) * 4);
         serve(4'h0, LAT_TRAP);
      end
      $display("trap done");
      for (int k = 0; k < 9; k++) begin
         ccfg[k % 8] <= '{1'($urandom), 1'($urandom), k[0]};
         s = 16'($urandom);
         d = 16'($urandom);
         ld[k % 8] <= 1'b1;
         ldv <= '{s, d, (k == 8) ? 8'h00 : 8'h03};
         cv[0] = '{1'b0, 1'b1, 1'b1, 3'(k), 4'h3};
         cfg <= cv;
         @(posedge clk);
         ld <= '0;
         hw_req[0] <= 1'b1;
         @(posedge clk);
         hw_req[0] <= 1'b0;
         e = ccfg[k % 8].word ? 16'h2 : 16'h1;
         if (k == 8) begin
            qv.push_back(48'h40);
            serve(4'h3, LAT_STD);
         end else begin
            qx.push_back({14'h0, 1'b1, ccfg[k].word, s, d});
            repeat (4) @(negedge clk);
            chk("chan", 48'(cst[k]), 48'({ccfg[k].inc_dst ? s : s + e,
               ccfg[k].inc_dst ? d + e : d, k[0] ? 8'h03 : 8'h02}));
            @(posedge clk);
         end
      end
      $display("transfer done");
      for (int sl = 0; sl < 3; sl++) begin
         for (int ed = 1; ed < 4; ed++) begin
            fsel <= {2'(sl), 2'(sl)};
            fedge <= {2'(ed), 2'(ed)};
            fclr <= 2'h3;
            @(posedge clk);
            fclr <= 2'h0;
            setl(sl, 1'b1);
            repeat (6) @(negedge clk);
            chk("rise", fflag, {2{ed[0]}});
            @(posedge clk);
            fclr <= 2'h3;
            @(posedge clk);
            fclr <= 2'h0;
            setl(sl, 1'b0);
            repeat (6) @(negedge clk);
            chk("fall", fflag, {2{ed[1]}});
            @(posedge clk);
         end
      end
      $display("fast done");
      chk("left", 48'(qv.size() + qx.size()), 48'h0);
      report_and_stop();
   end
endmodule // piet_ctrl_test
bind piet_ctrl piet_ctrl_monitor piet_ctrl_monitor_inst (.ref_clk_in(ref_clk_in),
   .rst_in(rst_in), .ack_in(ack_in), .reti_in(reti_in), .fast_clr_in(fast_clr_in),
   .fast_flag_out(fast_flag_out), .irq_out(irq_out), .vector_out(vector_out),
   .cur_prio_out(cur_prio_out), .xfer_out(xfer_out), .steal_out(steal_out));

// *** piet_fast_edge.sv ***
// one fast external interrupt input with source select and edge detection
// assumes pin and peripheral lines are asynchronous to ref_clk_in
`timescale 1ns/1ps
`include "piet_consts.svh"
module piet_fast_edge (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       clk_en_in,
   // sources and configuration
   input  wire logic       pin_in,
   input  wire logic       can_receive_line_in,
   input  wire logic       scl_in,
   input  wire logic [1:0] sel_in,
   input  wire logic [1:0] edge_in,
   // detected event
   output logic            hit_out
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic       last;
      logic       hit;
   } piet_fe_state_t;
   piet_fe_state_t st;
   piet_fe_state_t next_st;
   logic           cur;
   always_comb begin
      next_st = st;
      next_st.s1 = {scl_in, can_receive_line_in, pin_in};
      next_st.s2 = st.s1;
      unique case (sel_in)
         `PIET_FSEL_CAN: cur = st.s2[1];
         `PIET_FSEL_SCL: cur = st.s2[2];
         default:        cur = st.s2[0];
      endcase
      next_st.last = cur;
      next_st.hit = (edge_in[0] & cur & ~st.last) | (edge_in[1] & ~cur & st.last);
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end
   assign hit_out = st.hit;
endmodule // piet_fast_edge

// *** piet_pkg.sv ***
// types shared by the interrupt and event block
// assumes piet_consts.svh is on the include path
`include "piet_consts.svh"
package piet_pkg;
   typedef struct packed {
      logic                     req;
      logic                     en;
      logic                     use_xfer;
      logic [2:0]               chan;
      logic [`PIET_PRIO_W-1:0]  prio;
   } piet_ctrl_t;
   typedef struct packed {
      logic [`PIET_PTR_W-1:0]   src_ptr;
      logic [`PIET_PTR_W-1:0]   dst_ptr;
      logic [`PIET_CNT_W-1:0]   count;
   } piet_chan_t;
   typedef struct packed {
      logic                     word;
      logic                     inc_dst;
      logic                     continuous;
   } piet_chcfg_t;
   typedef struct packed {
      logic                     valid;
      logic                     is_word;
      logic [`PIET_PTR_W-1:0]   src;
      logic [`PIET_PTR_W-1:0]   dst;
   } piet_xfer_t;
   typedef enum logic [2:0] {
      PIET_IDLE = 3'h1,
      PIET_WAIT = 3'h2,
      PIET_GO   = 3'h4
   } piet_state_t;
endpackage
